// ===== inc/bmm_pkg.sv
// package of constants and types for the banked memory map block
package bmm_pkg;
    // ------------------------------------------------------------
    // program memory geometry
    // ------------------------------------------------------------
    localparam int PC_W = 13;                     // program counter width
    localparam int PWORD_W = 14;                  // program word width
    localparam int IMPL_PC_W = 12;                // implemented depth 4k words, upper addresses wrap
    localparam logic [12:0] RESET_VEC = 13'h0000; // fetch start after reset
    localparam logic [12:0] INT_VEC = 13'h0004;   // fetch start on interrupt
    // ------------------------------------------------------------
    // data memory geometry
    // ------------------------------------------------------------
    localparam int DATA_W = 8;                    // data byte width
    localparam int INBANK_W = 7;                  // in-bank address width, 0 to 7fh
    localparam int DADDR_W = 9;                   // full address: bank bits above in-bank address
    localparam int NBANKS = 4;                    // banks 0..3
    localparam logic [6:0] SFR_TOP = 7'h1F;       // last sfr location of each bank
    localparam int GPR_PER_BANK = 96;             // 20h..7fh general purpose bytes
    localparam int GPR_IDX_W = 9;                 // index width into gpr storage
    localparam int STATUS_BSH = 6;                // bank select high bit of status
    localparam int STATUS_BSL = 5;                // bank select low bit of status
    // mirrored special register locations, reachable in every bank
    localparam logic [6:0] SFR_INDIRECT = 7'h00;  // indirect access location
    localparam logic [6:0] SFR_PCLOW = 7'h02;     // program counter low byte
    localparam logic [6:0] SFR_STATUS = 7'h03;    // status register
    localparam logic [6:0] SFR_POINTER = 7'h04;   // indirect pointer register
    localparam logic [6:0] SFR_PCHIGH = 7'h0A;    // program counter latch high
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [7:0] STATUS_RST = 8'h18;    // status after reset, bank 0
    localparam logic [7:0] POINTER_RST = 8'h00;   // indirect pointer after reset
    localparam logic [4:0] PCHIGH_RST = 5'h00;    // program counter latch after reset
    // ------------------------------------------------------------
    // fetch sequencer states
    // ------------------------------------------------------------
    typedef enum logic [1:0]
    {
        BMM_RESET = 2'b00,
        BMM_RUN = 2'b01
    } bmm_fetch_e;
endpackage

// ===== verification/bmm_pmem_model.sv
// program memory model answering the fetch address of the block
`timescale 1ns/1ps
module bmm_pmem_model
(
    input wire logic [bmm_pkg::IMPL_PC_W-1:0] pmem_addr,
    output logic [bmm_pkg::PWORD_W-1:0] pmem_rdata
);
    // ----------------------------------------
    // word store
    // ----------------------------------------
    // each word carries its own address so a wrong fetch address shows up
    always_comb
    begin
        pmem_rdata = {2'b10, pmem_addr};
    end
endmodule

// ===== verification/tb_banked_memory_map.sv
// self-checking testbench of the banked memory map block
`timescale 1ns/1ps
module tb_banked_memory_map;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic fetch_adv = 1'b0;
    logic irq_take = 1'b0;
    logic jump_en = 1'b0;
    logic [12:0] jump_addr = 13'h0000;
    logic [13:0] pmem_rdata;
    logic [12:0] pc;
    logic [11:0] pmem_addr;
    logic [13:0] instr;
    logic d_rd = 1'b0;
    logic d_wr = 1'b0;
    logic [6:0] d_offset = 7'h00;
    logic [7:0] d_wdata = 8'h00;
    logic [7:0] d_rdata;
    logic [8:0] d_addr;
    logic d_is_sfr;
    logic [7:0] status_reg;
    logic [7:0] indirect_pointer_register;
    int miscompares = 0;
    int checked = 0;
    int cycles = 0;
    // ----------------------------------------
    // clock, design, memory model
    // ----------------------------------------
    // 50 ns period
    always #25 clk = ~clk;
    bmm_memory_map dut_u (.clk(clk), .rst(rst), .fetch_adv(fetch_adv), .irq_take(irq_take),
        .jump_en(jump_en), .jump_addr(jump_addr), .pmem_rdata(pmem_rdata), .pc(pc),
        .pmem_addr(pmem_addr), .instr(instr), .d_rd(d_rd), .d_wr(d_wr), .d_offset(d_offset),
        .d_wdata(d_wdata), .d_rdata(d_rdata), .d_addr(d_addr), .d_is_sfr(d_is_sfr),
        .status_reg(status_reg), .indirect_pointer_register(indirect_pointer_register));
    bmm_pmem_model mem_u (.pmem_addr(pmem_addr), .pmem_rdata(pmem_rdata));
    // ----------------------------------------
    // shared tasks
    // ----------------------------------------
    // compare one value, count and report a difference
    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // closing verdict, the one place the run ends
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // one data access, outputs sampled 1 ns after the taking edge
    task automatic acc(input logic wr, input logic [6:0] off, input logic [7:0] wd);
        @(posedge clk);
        d_rd <= ~wr;
        d_wr <= wr;
        d_offset <= off;
        d_wdata <= wd;
        @(posedge clk);
        d_rd <= 1'b0;
        d_wr <= 1'b0;
        #1;
    endtask
    // select a data bank through the status register
    task automatic set_bank(input logic [1:0] b);
        acc(1'b1, 7'h03, 8'h18 | {1'b0, b, 5'h00});
        chk("status", status_reg, 8'h18 | {1'b0, b, 5'h00});
    endtask
    // one fetch request with optional jump and interrupt in the same cycle
    task automatic fetch(input logic adv, input logic irq, input logic jmp, input logic [12:0] ja);
        @(posedge clk);
        fetch_adv <= adv;
        irq_take <= irq;
        jump_en <= jmp;
        jump_addr <= ja;
        @(posedge clk);
        fetch_adv <= 1'b0;
        irq_take <= 1'b0;
        jump_en <= 1'b0;
        #1;
    endtask
    // write then read of one offset in consecutive cycles
    task automatic b2b(input logic [6:0] off, input logic [7:0] wd);
        @(posedge clk);
        d_wr <= 1'b1;
        d_offset <= off;
        d_wdata <= wd;
        @(posedge clk);
        d_wr <= 1'b0;
        d_rd <= 1'b1;
        @(posedge clk);
        d_rd <= 1'b0;
        #1;
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    // fetch start, jump above 4k, wrap of the fetch address
    task automatic test_fetch;
        chk("pc after reset", pc, 13'h0000);
        chk("status after reset", status_reg, 8'h18);
        chk("pointer after reset", indirect_pointer_register, 8'h00);
        fetch(1'b0, 1'b0, 1'b1, 13'h1FFE);
        chk("pmem addr", pmem_addr, 12'hFFE);
        fetch(1'b1, 1'b0, 1'b0, 13'h0000);
        chk("instr", instr, {2'b10, 12'hFFE});
        chk("pc", pc, 13'h1FFF);
        fetch(1'b1, 1'b0, 1'b0, 13'h0000);
        chk("pc wrap", pc, 13'h0000);
        fetch(1'b1, 1'b1, 1'b1, 13'h0123);
        chk("pc irq", pc, 13'h0004);
        $display("test fetch done");
    endtask
    // every bank keeps its own general purpose bytes
    task automatic test_banks;
        for (int b = 0; b < 4; b++)
        begin
            set_bank(b[1:0]);
            acc(1'b1, 7'h20, 8'hA0 + b[7:0]);
            chk("d_addr low gpr", d_addr, {b[1:0], 7'h20});
            chk("is_sfr 20h", d_is_sfr, 1'b0);
            acc(1'b1, 7'h7F, 8'h50 + b[7:0]);
            chk("d_addr top", d_addr, {b[1:0], 7'h7F});
        end
        for (int b = 3; b >= 0; b--)
        begin
            set_bank(b[1:0]);
            acc(1'b0, 7'h20, 8'h00);
            chk("gpr 20h", d_rdata, 8'hA0 + b[7:0]);
            acc(1'b0, 7'h7F, 8'h00);
            chk("gpr 7fh", d_rdata, 8'h50 + b[7:0]);
            acc(1'b0, 7'h1F, 8'h00);
            chk("is_sfr 1fh", d_is_sfr, 1'b1);
        end
        $display("test banks done");
    endtask
    // mirrored pointer, indirect access, fetch beside a data access
    task automatic test_mirror;
        set_bank(2'b11);
        acc(1'b1, 7'h04, 8'hA0);
        chk("pointer", indirect_pointer_register, 8'hA0);
        set_bank(2'b01);
        acc(1'b0, 7'h04, 8'h00);
        chk("mirror pointer", d_rdata, 8'hA0);
        chk("is_sfr 04h", d_is_sfr, 1'b1);
        acc(1'b1, 7'h00, 8'h3C);
        chk("indirect addr", d_addr, 9'h0A0);
        acc(1'b0, 7'h20, 8'h00);
        chk("indirect target", d_rdata, 8'h3C);
        @(posedge clk);
        fetch_adv <= 1'b1;
        d_rd <= 1'b1;
        d_offset <= 7'h20;
        @(posedge clk);
        fetch_adv <= 1'b0;
        d_rd <= 1'b0;
        #1;
        chk("pc beside data", pc, 13'h0005);
        chk("data beside fetch", d_rdata, 8'h3C);
        $display("test mirror done");
    endtask
    // back to back accesses, mirrored locations, ignored sfr writes
    task automatic test_b2b;
        b2b(7'h03, 8'h58);
        chk("status b2b", d_rdata, 8'h58);
        b2b(7'h40, 8'h6B);
        chk("gpr b2b", d_rdata, 8'h6B);
        b2b(7'h0A, 8'hFF);
        chk("pc latch", d_rdata, 8'h1F);
        b2b(7'h05, 8'hFF);
        chk("other sfr", d_rdata, 8'h00);
        acc(1'b0, 7'h02, 8'h00);
        chk("pc low", d_rdata, 8'h05);
        $display("test b2b done");
    endtask
    // reset in mid-run returns fetch and bank state to their start
    task automatic test_reset;
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        chk("pc after rerun", pc, 13'h0000);
        chk("status after rerun", status_reg, 8'h18);
        chk("pointer after rerun", indirect_pointer_register, 8'h00);
        acc(1'b0, 7'h20, 8'h00);
        chk("d_addr bank 0", d_addr, 9'h020);
        $display("test reset done");
    endtask
    // ----------------------------------------
    // hang guard and main sequence
    // ----------------------------------------
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 2000)
        begin
            miscompares++;
            report_and_stop;
        end
    end
    initial
    begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        test_fetch;
        test_banks;
        test_mirror;
        test_b2b;
        test_reset;
        report_and_stop;
    end
endmodule

// ===== verilog/bmm_gpr_ram.sv
// general purpose static ram storage of the banked data memory
`timescale 1ns/1ps
module bmm_gpr_ram
(
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [bmm_pkg::GPR_IDX_W-1:0] idx,
    input wire logic [bmm_pkg::DATA_W-1:0] wdata,
    output logic [bmm_pkg::DATA_W-1:0] rdata
);
    // ------------------------------------------------------------
    // storage and state
    // ------------------------------------------------------------
    localparam int DEPTH = bmm_pkg::GPR_PER_BANK * bmm_pkg::NBANKS; // 384 bytes
    typedef struct packed
    {
        logic [DEPTH-1:0][bmm_pkg::DATA_W-1:0] mem; // byte array
        logic [bmm_pkg::DATA_W-1:0] rd;             // registered read data
    } bmm_ram_s;
    bmm_ram_s st_ff;
    bmm_ram_s nxt_st;

    // read returns old data on a same-cycle write
    always_comb
    begin
        nxt_st = st_ff;
        if (idx < 9'(DEPTH))
        begin
            nxt_st.rd = st_ff.mem[idx];
            if (wr_en)
            begin
                nxt_st.mem[idx] = wdata;
            end
        end
        else
        begin
            nxt_st.rd = 8'h00; // out of range reads as zero
        end
    end

    // register whole state; ram content also cleared on reset
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    assign rdata = st_ff.rd;
endmodule

// ===== verilog/bmm_memory_map.sv
// banked memory map: program counter, vectors, bank decode, mirrored registers
`timescale 1ns/1ps
// Contract
// - 13-bit counter, 8k by 14-bit program space
// - addresses above implemented memory wrap around
// - fetch starts at 0000h after reset
// - interrupt redirects fetch to 0004h
// - status bits 6:5 select banks 0-3
// - banks hold special and general registers
// - each bank spans 0 to 7fh
// - low bank addresses decode to special registers
// - addresses above special region are static ram
// - every bank has a special register region
// - mirrored special registers reach one physical copy
// - separate fetch and data buses, same cycle
// - direct or indirect access through pointer register
module bmm_memory_map
(
    input wire logic clk,
    input wire logic rst,
    // fetch side from the core
    input wire logic fetch_adv,
    input wire logic irq_take,
    input wire logic jump_en,
    input wire logic [bmm_pkg::PC_W-1:0] jump_addr,
    input wire logic [bmm_pkg::PWORD_W-1:0] pmem_rdata,
    output logic [bmm_pkg::PC_W-1:0] pc,
    output logic [bmm_pkg::IMPL_PC_W-1:0] pmem_addr,
    output logic [bmm_pkg::PWORD_W-1:0] instr,
    // data side from the core
    input wire logic d_rd,
    input wire logic d_wr,
    input wire logic [bmm_pkg::INBANK_W-1:0] d_offset,
    input wire logic [bmm_pkg::DATA_W-1:0] d_wdata,
    output logic [bmm_pkg::DATA_W-1:0] d_rdata,
    output logic [bmm_pkg::DADDR_W-1:0] d_addr,
    output logic d_is_sfr,
    output logic [bmm_pkg::DATA_W-1:0] status_reg,
    output logic [bmm_pkg::DATA_W-1:0] indirect_pointer_register
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed
    {
        bmm_pkg::bmm_fetch_e fsm;                 // fetch sequencer
        logic [bmm_pkg::PC_W-1:0] pc;             // program counter
        logic [bmm_pkg::PWORD_W-1:0] instr;       // fetched word
        logic [bmm_pkg::DATA_W-1:0] status;       // status, holds bank bits
        logic [bmm_pkg::DATA_W-1:0] ptr;          // indirect pointer
        logic [4:0] pchigh;                       // program counter latch
        logic [bmm_pkg::DADDR_W-1:0] daddr;       // last decoded address
        logic is_sfr;                             // last access hit sfr region
        logic sfr_rd;                             // sfr read pending in output
        logic [bmm_pkg::DATA_W-1:0] sfr_data;     // registered sfr read data
    } bmm_map_s;
    bmm_map_s st_ff;
    bmm_map_s nxt_st;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // full address from bank bits and a 7-bit offset
    function automatic logic [8:0] join_addr(input logic [7:0] stat, input logic [6:0] off);
        join_addr = {stat[bmm_pkg::STATUS_BSH], stat[bmm_pkg::STATUS_BSL], off};
    endfunction

    // sfr region test, same in every bank
    function automatic logic in_sfr(input logic [8:0] a);
        in_sfr = (a[6:0] <= bmm_pkg::SFR_TOP);
    endfunction

    // gpr storage index: bank times 96 plus offset above sfr region
    function automatic logic [8:0] gpr_index(input logic [8:0] a);
        logic [8:0] base;
        base = 9'(a[8:7]) * 9'(bmm_pkg::GPR_PER_BANK);
        gpr_index = base + 9'(a[6:0]) - (9'(bmm_pkg::SFR_TOP) + 9'h001);
    endfunction

    logic [8:0] direct_a;    // bank bits plus offset
    logic [8:0] eff_a;       // effective address after indirect
    logic use_ind;           // offset names the indirect location
    logic [bmm_pkg::DATA_W-1:0] gpr_rdata;
    logic gpr_we;

    // indirect location redirects to the pointer; bank high bit
    // extends the pointer so all four banks stay reachable
    always_comb
    begin
        direct_a = join_addr(st_ff.status, d_offset);
        use_ind = (d_offset == bmm_pkg::SFR_INDIRECT);
        if (use_ind)
        begin
            eff_a = {st_ff.status[bmm_pkg::STATUS_BSH], st_ff.ptr};
        end
        else
        begin
            eff_a = direct_a;
        end
        gpr_we = d_wr && !in_sfr(eff_a);
    end

    // gpr ram on its own data bus, independent of fetch
    bmm_gpr_ram u_gpr
    (
        .clk(clk),
        .rst(rst),
        .wr_en(gpr_we),
        .idx(gpr_index(eff_a)),
        .wdata(d_wdata),
        .rdata(gpr_rdata)
    );

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        // fetch sequencer, independent of data accesses
        case (st_ff.fsm)
            bmm_pkg::BMM_RESET:
            begin
                nxt_st.pc = bmm_pkg::RESET_VEC;
                nxt_st.fsm = bmm_pkg::BMM_RUN;
            end
            bmm_pkg::BMM_RUN:
            begin
                // interrupt beats jump beats sequential advance
                if (irq_take)
                begin
                    nxt_st.pc = bmm_pkg::INT_VEC;
                end
                else if (jump_en)
                begin
                    nxt_st.pc = jump_addr;
                end
                else if (fetch_adv)
                begin
                    nxt_st.pc = st_ff.pc + 13'h0001; // wraps at 8k
                end
                if (fetch_adv)
                begin
                    nxt_st.instr = pmem_rdata;
                end
            end
            default:
            begin
                nxt_st.fsm = bmm_pkg::BMM_RESET;
            end
        endcase
        // data access, same cycle as any fetch
        nxt_st.sfr_rd = 1'b0;
        if (d_rd || d_wr)
        begin
            nxt_st.daddr = eff_a;
            nxt_st.is_sfr = in_sfr(eff_a);
        end
        if (d_rd && in_sfr(eff_a))
        begin
            nxt_st.sfr_rd = 1'b1;
            // mirrored locations ignore bank bits
            if (eff_a[6:0] == bmm_pkg::SFR_STATUS)
            begin
                nxt_st.sfr_data = st_ff.status;
            end
            else if (eff_a[6:0] == bmm_pkg::SFR_POINTER)
            begin
                nxt_st.sfr_data = st_ff.ptr;
            end
            else if (eff_a[6:0] == bmm_pkg::SFR_PCLOW)
            begin
                nxt_st.sfr_data = st_ff.pc[7:0];
            end
            else if (eff_a[6:0] == bmm_pkg::SFR_PCHIGH)
            begin
                nxt_st.sfr_data = {3'b000, st_ff.pchigh};
            end
            else
            begin
                nxt_st.sfr_data = 8'h00; // other sfrs live outside this block
            end
        end
        if (d_wr && in_sfr(eff_a))
        begin
            if (eff_a[6:0] == bmm_pkg::SFR_STATUS)
            begin
                nxt_st.status = d_wdata;
            end
            else if (eff_a[6:0] == bmm_pkg::SFR_POINTER)
            begin
                nxt_st.ptr = d_wdata;
            end
            else if (eff_a[6:0] == bmm_pkg::SFR_PCHIGH)
            begin
                nxt_st.pchigh = d_wdata[4:0];
            end
            else
            begin
                nxt_st.sfr_data = st_ff.sfr_data; // nothing stored here
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            st_ff.fsm <= bmm_pkg::BMM_RESET;
            st_ff.pc <= bmm_pkg::RESET_VEC;
            st_ff.instr <= '0;
            st_ff.status <= bmm_pkg::STATUS_RST;
            st_ff.ptr <= bmm_pkg::POINTER_RST;
            st_ff.pchigh <= bmm_pkg::PCHIGH_RST;
            st_ff.daddr <= '0;
            st_ff.is_sfr <= 1'b0;
            st_ff.sfr_rd <= 1'b0;
            st_ff.sfr_data <= '0;
        end
        else
        begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // outputs, all from flip-flops except read mux of two flops
    // ------------------------------------------------------------
    assign pc = st_ff.pc;
    assign pmem_addr = st_ff.pc[bmm_pkg::IMPL_PC_W-1:0];
    assign instr = st_ff.instr;
    assign d_rdata = st_ff.sfr_rd ? st_ff.sfr_data : gpr_rdata;
    assign d_addr = st_ff.daddr;
    assign d_is_sfr = st_ff.is_sfr;
    assign status_reg = st_ff.status;
    assign indirect_pointer_register = st_ff.ptr;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    pc_reset_a: assert property (@(posedge clk) disable iff (rst)
        $rose(st_ff.fsm == bmm_pkg::BMM_RUN) |-> pc == 13'h0000)
        else $error("pc not at reset vector");
    irq_vec_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.fsm == bmm_pkg::BMM_RUN && irq_take) |=> pc == 13'h0004)
        else $error("interrupt vector missed");
    pc_wrap_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.fsm == bmm_pkg::BMM_RUN && jump_en && !irq_take) |=> pmem_addr == $past(jump_addr[11:0]))
        else $error("program address not wrapped");
    pc_incr_a: assert property (@(posedge clk) disable iff (rst)
        (st_ff.fsm == bmm_pkg::BMM_RUN && fetch_adv && !irq_take && !jump_en) |=> pc == $past(pc) + 13'h0001)
        else $error("pc did not advance");
    bank_join_a: assert property (@(posedge clk) disable iff (rst)
        ((d_rd || d_wr) && d_offset != 7'h00) |=> d_addr == {$past(status_reg[6:5]), $past(d_offset)})
        else $error("direct address wrong");
    sfr_low_a: assert property (@(posedge clk) disable iff (rst)
        ((d_rd || d_wr) && d_offset != 7'h00) |=> d_is_sfr == ($past(d_offset) <= 7'h1F))
        else $error("sfr decode wrong");
    mirror_a: assert property (@(posedge clk) disable iff (rst)
        (d_wr && d_offset == 7'h03) ##1 (d_rd && d_offset == 7'h03) |=> d_rdata == $past(d_wdata, 2))
        else $error("mirrored status not shared");
    indirect_a: assert property (@(posedge clk) disable iff (rst)
        ((d_rd || d_wr) && d_offset == 7'h00) |=> d_addr == {$past(status_reg[6]), $past(indirect_pointer_register)})
        else $error("indirect address wrong");
    gpr_ram_a: assert property (@(posedge clk) disable iff (rst)
        (d_wr && d_offset == 7'h40) ##1 (d_rd && d_offset == 7'h40 && $stable(status_reg))
        |=> d_rdata == $past(d_wdata, 2))
        else $error("gpr storage lost data");
    cover_irq_c: cover property (@(posedge clk) disable iff (rst) irq_take ##1 pc == 13'h0004);
    cover_bank3_c: cover property (@(posedge clk) disable iff (rst) d_wr && status_reg[6:5] == 2'b11);
    cover_both_c: cover property (@(posedge clk) disable iff (rst) fetch_adv && d_rd);
endmodule
